// file: bench/raat_core_assertions.sv
`timescale 1ns/1ps
// ====
// Protocol checks at the ports of the transaction handler.
module raat_core_assertions
	import raat_pkg::*;
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst_n,
	// Configuration.
	input wire logic primary_transmitter,
	input wire logic auto_ack_enable,
	input wire logic crc_enable,
	input wire logic [2:0] flag_clear,
	// Status.
	input wire raat_flags_t flags,
	input wire logic irq,
	input wire logic tx_fifo_pop,
	// Front end.
	input wire logic tx_start,
	input wire raat_tx_hdr_t tx_hdr,
	input wire logic tx_done,
	input wire logic rx_on,
	input wire logic rx_addr_match,
	input wire logic rx_valid,
	input wire raat_rx_hdr_t rx_hdr
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	sequence s_ack;
		rx_valid && rx_on && primary_transmitter && rx_hdr.kind == RAAT_PKT_ACK && rx_hdr.crc_ok;
	endsequence
	sequence s_sent;
		tx_fifo_pop ##1 flags.tx_data_sent_flag;
	endsequence
	irq_any_flag_a: assert property (irq == (|flags))
		else $error("irq differs from flags");
	ack_done_a: assert property (s_ack |=> s_sent)
		else $error("ack did not complete the send");
	listen_after_a: assert property (primary_transmitter && auto_ack_enable && tx_done |=> rx_on)
		else $error("no listen after send");
	addr_hold_a: assert property (rx_on && rx_addr_match |=> rx_on)
		else $error("listen dropped during packet");
	sent_sticky_a: assert property (flags.tx_data_sent_flag && !flag_clear[1] |=> flags.tx_data_sent_flag)
		else $error("sent flag lost");
	legacy_hdr_a: assert property (tx_start && !auto_ack_enable |-> !tx_hdr.has_ctrl && tx_hdr.has_crc == crc_enable)
		else $error("legacy header wrong");
	limit_fail_a: assert property ($rose(flags.retry_limit_flag) |-> !$rose(flags.tx_data_sent_flag) && !$past(tx_fifo_pop))
		else $error("retry limit ended as sent");
	ack_reply_a: assert property (rx_valid && !primary_transmitter && auto_ack_enable && rx_hdr.crc_ok
		&& rx_hdr.kind == RAAT_PKT_DATA |=> tx_start && tx_hdr.kind == RAAT_PKT_ACK
		&& tx_hdr.packet_identifier == $past(rx_hdr.packet_identifier))
		else $error("no ack for data");
endmodule
bind raat_core raat_core_assertions u_chk (.*);

// file: bench/raat_peer.sv
`timescale 1ns/1ps
// ====
// Peer radio: ends each send, acks data and sends data on request.
module raat_peer
	import raat_pkg::*;
(
	// Clock.
	input wire logic mclk,
	// Bench control.
	input wire logic send,
	input wire logic [1:0] spid,
	input wire logic ack_en,
	input wire logic ack_pay,
	// Front end.
	input wire logic tx_start,
	input wire raat_tx_hdr_t tx_hdr,
	output logic tx_done,
	output logic rx_addr_match,
	output logic rx_valid,
	output raat_rx_hdr_t rx_hdr
);
	raat_rx_hdr_t hdr_q = '0;
	int cnt = 0;
	// Outside a packet the header shows the inverse of the last value.
	assign rx_hdr = rx_valid ? hdr_q : ~hdr_q;
	always @(posedge mclk)
	begin
		cnt <= tx_start ? 3 : (cnt > 0 ? cnt - 1 : 0);
		tx_done <= (cnt == 1);
	end
	task pkt(input logic [1:0] k, input logic [1:0] p, input logic pay);
		@(posedge mclk) rx_addr_match <= 1'b1;
		@(posedge mclk) rx_addr_match <= 1'b0;
		rx_valid <= 1'b1;
		hdr_q <= '{k, p, pay, 1'b1};
		@(posedge mclk) rx_valid <= 1'b0;
	endtask
	initial
	begin
		rx_addr_match = 1'b0;
		rx_valid = 1'b0;
		forever
		begin
			@(posedge mclk);
			if (send)
				pkt(RAAT_PKT_DATA, spid, 1'b0);
			else if (tx_done && tx_hdr.kind == RAAT_PKT_DATA && ack_en)
				pkt(RAAT_PKT_ACK, tx_hdr.packet_identifier, ack_pay);
		end
	end
endmodule

// file: bench/raat_tb_top.sv
`timescale 1ns/1ps
// ====
// Self-checking bench for the transaction handler.
module raat_core_tb_top
	import raat_pkg::*;
;
	logic mclk = 0, rst_n = 0, prim_tx = 0, ce = 0, aa = 0, crc = 0, fifo = 0, apend = 0;
	logic send = 0, ack_en = 0, ack_pay = 0, txs, txd, am, rxv;
	logic irq, txpop, apop, rxpush;
	logic [1:0] spid = 0, p0;
	logic [3:0] lim = 0, rcnt;
	logic [2:0] clr = 0;
	raat_flags_t flags;
	raat_tx_hdr_t th;
	raat_rx_hdr_t rh;
	int err_total = 0, checked = 0, seed = 32'h32f1;
	int n_pop = 0, n_apop = 0, n_push = 0;
	logic [1:0] pq[$];
	always #25 mclk = ~mclk;
	always @(posedge mclk) if (txs) pq.push_back(th.packet_identifier);
	always @(posedge mclk) if (txpop) n_pop <= n_pop + 1;
	always @(posedge mclk) if (apop) n_apop <= n_apop + 1;
	always @(posedge mclk) if (rxpush) n_push <= n_push + 1;
	raat_core #(.ACK_WAIT_CYC(20)) dut (.mclk(mclk), .rst_n(rst_n), .primary_transmitter(prim_tx),
		.chip_enable(ce), .auto_ack_enable(aa), .crc_enable(crc), .retry_limit_setting(lim),
		.tx_fifo_has_payload(fifo), .ack_payload_pending(apend), .flag_clear(clr),
		.flags(flags), .irq(irq), .retry_count(rcnt), .tx_fifo_pop(txpop), .ack_payload_pop(apop),
		.rx_fifo_push(rxpush), .tx_start(txs), .tx_hdr(th), .tx_done(txd), .rx_on(),
		.rx_addr_match(am), .rx_valid(rxv), .rx_hdr(rh));
	raat_peer peer (.mclk(mclk), .send(send), .spid(spid), .ack_en(ack_en), .ack_pay(ack_pay),
		.tx_start(txs), .tx_hdr(th), .tx_done(txd), .rx_addr_match(am), .rx_valid(rxv),
		.rx_hdr(rh));
	task cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e)
		begin
			err_total++;
			$display("[ERR] %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task test_done;
		if (err_total == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task kick;
		cyc(2600);
		clr <= 3'h7;
		cyc(1);
		clr <= 3'h0;
		ce <= 1'b1;
		pq = {};
		cyc(200);
		ce <= 1'b0;
		cyc(1);
	endtask
	task rx(input logic [1:0] p);
		clr <= 3'h7;
		spid <= p;
		cyc(1);
		clr <= 3'h0;
		send <= 1'b1;
		pq = {};
		cyc(1);
		send <= 1'b0;
		cyc(20);
	endtask
	initial
	begin
		#2ms;
		err_total++;
		test_done;
	end
	initial
	begin
		cyc(16);
		rst_n <= 1'b1;
		prim_tx <= 1'b1;
		aa <= 1'b1;
		fifo <= 1'b1;
		lim <= 4'h3;
		ack_en <= 1'b1;
		ack_pay <= 1'b1;
		kick;
		p0 = pq[0];
		chk(flags, 3'h6);
		chk(pq.size(), 1);
		chk(irq, 1);
		chk(n_pop, 1);
		chk(n_push, 1);
		ack_en <= 1'b0;
		lim <= 4'($unsigned($random(seed)) % 3);
		kick;
		chk(flags, 3'h1);
		chk(rcnt, lim);
		chk(pq.size(), lim + 1);
		chk(n_pop, 1);
		foreach (pq[i]) chk(pq[i], 2'(p0 + 2'h1));
		ack_en <= 1'b1;
		kick;
		chk(pq[0], 2'(p0 + 2'h1));
		chk(flags, 3'h6);
		chk(n_pop, 2);
		chk(n_push, 2);
		fifo <= 1'b0;
		kick;
		chk(pq.size(), 0);
		prim_tx <= 1'b0;
		ce <= 1'b1;
		rx(2'h2);
		chk(flags, 3'h4);
		chk(pq[0], 2'h2);
		chk(n_push, 3);
		apend <= 1'b1;
		rx(2'h2);
		chk(flags, 3'h0);
		chk(pq.size(), 1);
		chk(irq, 0);
		chk(n_push, 3);
		apend <= 1'b0;
		rx(2'h3);
		chk(flags, 3'h6);
		chk(n_apop, 1);
		chk(n_push, 4);
		prim_tx <= 1'b1;
		ce <= 1'b0;
		ack_en <= 1'b0;
		aa <= 1'b0;
		lim <= 4'h0;
		crc <= 1'($random(seed));
		fifo <= 1'b1;
		kick;
		chk(th.has_ctrl, 0);
		chk(th.has_crc, crc);
		chk(flags, 3'h2);
		chk(n_pop, 3);
		chk(n_push, 4);
		test_done;
	end
endmodule

// file: rtl/raat_core.sv
`timescale 1ns/1ps
// Behaviour
// - Receiver flags data; transmitter flags sent on acknowledge, or at the end of the send for legacy packets.
// - After sending, listen; resend if slot expires.
// - Address detected keeps receive until packet ends.
// - Retransmitted packet after loss: flag and acknowledge.
// - Acknowledge with payload sets sent and ready.
// - Receiver ack payload sent after next new packet.
// - Duplicate identifier discarded but still acknowledged.
// - Retries past limit end with retry limit flag.
// - Failed payload stays in transmit FIFO.
// - Legacy packets omit the 9 bit control field.
// - Legacy checksum present only when crc enabled.
module raat_core
	import raat_pkg::*;
#(
	parameter int ACK_WAIT_CYC = RAAT_ACK_WAIT_CYC
)
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst_n,
	// Controller configuration.
	input wire logic primary_transmitter,
	input wire logic chip_enable,
	input wire logic auto_ack_enable,
	input wire logic crc_enable,
	input wire logic [RAAT_RETRY_W-1:0] retry_limit_setting,
	input wire logic tx_fifo_has_payload,
	input wire logic ack_payload_pending,
	input wire logic [2:0] flag_clear,
	// Controller status.
	output raat_flags_t flags,
	output logic irq,
	output logic [RAAT_RETRY_W-1:0] retry_count,
	output logic tx_fifo_pop,
	output logic ack_payload_pop,
	output logic rx_fifo_push,
	// Radio front end.
	output logic tx_start,
	output raat_tx_hdr_t tx_hdr,
	input wire logic tx_done,
	output logic rx_on,
	input wire logic rx_addr_match,
	input wire logic rx_valid,
	input wire raat_rx_hdr_t rx_hdr
);

	// ==========================================================
	// Transaction state.
	typedef enum logic [4:0]
	{
		S_IDLE = 5'h01,
		S_SEND = 5'h02,
		S_WAIT = 5'h04,
		S_GRAB = 5'h08,
		S_DONE = 5'h10
	} raat_state_t;

	localparam int WAIT_W = $clog2(ACK_WAIT_CYC + 1);
	localparam logic [WAIT_W-1:0] WAIT_LAST = WAIT_W'(ACK_WAIT_CYC - 1);
	localparam logic [WAIT_W-1:0] WAIT_ZERO = '0;

	raat_state_t state_ff, nxt_state;
	logic [WAIT_W-1:0] wait_ff;
	logic [RAAT_RETRY_W-1:0] retry_ff;
	logic [RAAT_IDENT_W-1:0] tx_ident_ff;
	logic [RAAT_IDENT_W-1:0] last_rx_ident_ff;
	logic seen_rx_ff;
	logic ce_q_ff;
	logic ack_pay_out_ff;
	logic legacy;
	logic ce_rise;
	logic good_rx;
	logic ack_rx;
	logic data_rx;
	logic dup_rx;
	logic ev_ready, ev_sent, ev_limit;

	assign legacy = !auto_ack_enable;
	assign ce_rise = chip_enable && !ce_q_ff;
	assign good_rx = rx_valid && (rx_hdr.crc_ok || (legacy && !crc_enable));
	assign ack_rx = good_rx && rx_hdr.kind == RAAT_PKT_ACK;
	assign data_rx = good_rx && rx_hdr.kind == RAAT_PKT_DATA;
	// Duplicates only exist where identifiers are carried.
	assign dup_rx = data_rx && !legacy && seen_rx_ff
		&& rx_hdr.packet_identifier == last_rx_ident_ff;

	// ==========================================================
	// Transmitter sequencing.
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			S_IDLE:
			begin
				// A fresh enable edge restarts a left-over payload too.
				if (primary_transmitter && ce_rise && tx_fifo_has_payload)
					nxt_state = S_SEND;
			end
			S_SEND:
			begin
				if (tx_done)
					nxt_state = legacy ? S_DONE : S_WAIT;
			end
			S_WAIT:
			begin
				if (ack_rx)
					nxt_state = S_DONE;
				else if (rx_addr_match)
					nxt_state = S_GRAB;
				else if (wait_ff == WAIT_LAST)
					nxt_state = (retry_ff >= retry_limit_setting) ? S_IDLE : S_SEND;
			end
			S_GRAB:
			begin
				if (ack_rx)
					nxt_state = S_DONE;
				else if (rx_valid)
					nxt_state = (retry_ff >= retry_limit_setting) ? S_IDLE : S_SEND;
			end
			S_DONE:
				nxt_state = S_IDLE;
			default:
				nxt_state = S_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			state_ff <= S_IDLE;
		else
			state_ff <= nxt_state;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			ce_q_ff <= 1'b0;
		else
			ce_q_ff <= chip_enable;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			wait_ff <= WAIT_ZERO;
		else if (state_ff == S_WAIT)
			wait_ff <= wait_ff + 1'b1;
		else
			wait_ff <= WAIT_ZERO;
	end

	// Retry count restarts with each new sequence.
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			retry_ff <= RAAT_RETRY_ZERO;
		else if (state_ff == S_IDLE && nxt_state == S_SEND)
			retry_ff <= RAAT_RETRY_ZERO;
		else if ((state_ff == S_WAIT || state_ff == S_GRAB) && nxt_state == S_SEND)
			retry_ff <= retry_ff + RAAT_RETRY_STEP;
	end

	// The identifier advances only once a payload leaves the FIFO.
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			tx_ident_ff <= RAAT_IDENT_RST;
		else if (state_ff == S_DONE)
			tx_ident_ff <= tx_ident_ff + RAAT_IDENT_STEP;
	end

	// ==========================================================
	// Receiver duplicate tracking and ack payload ownership.
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			last_rx_ident_ff <= RAAT_IDENT_RST;
			seen_rx_ff <= 1'b0;
		end
		else if (!primary_transmitter && data_rx)
		begin
			last_rx_ident_ff <= rx_hdr.packet_identifier;
			seen_rx_ff <= 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			ack_pay_out_ff <= 1'b0;
		else if (!primary_transmitter && data_rx && !legacy)
			// An acknowledge resent for a duplicate may carry a freshly queued payload.
			ack_pay_out_ff <= ack_payload_pending || (dup_rx && ack_pay_out_ff);
	end

	// ==========================================================
	// Events and sticky flags.
	assign ev_ready = primary_transmitter
		? (ack_rx && rx_hdr.has_payload && state_ff inside {S_WAIT, S_GRAB})
		: (data_rx && !dup_rx);
	assign ev_sent = primary_transmitter ? (state_ff == S_DONE)
		: (data_rx && !dup_rx && ack_pay_out_ff);
	assign ev_limit = primary_transmitter && state_ff inside {S_WAIT, S_GRAB}
		&& nxt_state == S_IDLE;

	// A set in the same cycle as its clear wins.
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			flags <= '0;
		else
		begin
			flags.rx_data_ready_flag <= ev_ready || (flags.rx_data_ready_flag && !flag_clear[2]);
			flags.tx_data_sent_flag <= ev_sent || (flags.tx_data_sent_flag && !flag_clear[1]);
			flags.retry_limit_flag <= ev_limit || (flags.retry_limit_flag && !flag_clear[0]);
		end
	end

	assign irq = |flags;

	// ==========================================================
	// Front end and FIFO strobes.
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			tx_hdr <= '0;
		else if (nxt_state == S_SEND)
		begin
			tx_hdr.kind <= RAAT_PKT_DATA;
			tx_hdr.packet_identifier <= tx_ident_ff;
			tx_hdr.has_ctrl <= !legacy;
			tx_hdr.has_crc <= !legacy || crc_enable;
			tx_hdr.has_payload <= 1'b1;
		end
		else if (!primary_transmitter && data_rx && !legacy)
		begin
			tx_hdr.kind <= RAAT_PKT_ACK;
			tx_hdr.packet_identifier <= rx_hdr.packet_identifier;
			tx_hdr.has_ctrl <= 1'b1;
			tx_hdr.has_crc <= 1'b1;
			tx_hdr.has_payload <= ack_payload_pending;
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			tx_start <= 1'b0;
		else
			tx_start <= (state_ff != S_SEND && nxt_state == S_SEND)
				|| (!primary_transmitter && data_rx && !legacy);
	end

	assign rx_on = primary_transmitter ? (state_ff inside {S_WAIT, S_GRAB}) : chip_enable;
	// The payload leaves only on success; a failure keeps it queued.
	assign tx_fifo_pop = state_ff == S_DONE;
	assign ack_payload_pop = ev_sent && !primary_transmitter;
	assign rx_fifo_push = ev_ready && (!primary_transmitter || rx_hdr.has_payload);
	assign retry_count = retry_ff;

endmodule

// file: rtl/raat_pkg.sv
package raat_pkg;

	// Air-side packet types seen by the transaction handler.
	typedef enum logic [1:0]
	{
		RAAT_PKT_DATA = 2'h0,
		RAAT_PKT_ACK = 2'h1
	} raat_pkt_kind_t;

	// Header of a received packet, reported by the demodulator.
	typedef struct packed
	{
		logic [1:0] kind;
		logic [1:0] packet_identifier;
		logic has_payload;
		logic crc_ok;
	} raat_rx_hdr_t;

	// Header of a packet handed to the modulator.
	typedef struct packed
	{
		logic [1:0] kind;
		logic [1:0] packet_identifier;
		logic has_ctrl;
		logic has_crc;
		logic has_payload;
	} raat_tx_hdr_t;

	// Event flags seen by the controller.
	typedef struct packed
	{
		logic rx_data_ready_flag;
		logic tx_data_sent_flag;
		logic retry_limit_flag;
	} raat_flags_t;

	localparam int RAAT_IDENT_W = 2;
	localparam int RAAT_RETRY_W = 4;
	localparam logic [RAAT_IDENT_W-1:0] RAAT_IDENT_RST = 2'h0;
	localparam logic [RAAT_IDENT_W-1:0] RAAT_IDENT_STEP = 2'h1;
	localparam logic [RAAT_RETRY_W-1:0] RAAT_RETRY_ZERO = 4'h0;
	localparam logic [RAAT_RETRY_W-1:0] RAAT_RETRY_STEP = 4'h1;
	localparam int RAAT_CTRL_FIELD_BITS = 9;
	localparam int RAAT_CLK_MHZ = 20;
	localparam int RAAT_ACK_WAIT_US = 250;
	localparam int RAAT_ACK_WAIT_CYC = RAAT_ACK_WAIT_US * RAAT_CLK_MHZ;

endpackage
